/* logic/acc_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_shifter
   import cpu_slice_pkg::*;
#(
   parameter int unsigned IN_W = 16,
   parameter int unsigned OUT_W = 32
) (
   // Operand and shift
   input wire logic [IN_W-1:0] operand,
   input wire logic [cpu_slice_pkg::SHAMT_W-1:0] shiftAmount,
   input wire logic signExtend,
   // Result
   output logic [OUT_W-1:0] result
);
   logic [OUT_W-1:0] widened;

   // Widen first, then shift: zeros come in at the bottom
   always_comb begin
      if (signExtend) begin
         widened = {{(OUT_W-IN_W){operand[IN_W-1]}}, operand}; // RULE10
      end else begin
         widened = {{(OUT_W-IN_W){1'b0}}, operand}; // RULE10
      end
      result = widened << shiftAmount;
   end
endmodule
`default_nettype wire

/* logic/cpu_slice_pkg.sv */
package cpu_slice_pkg;
   // Data path widths
   localparam int unsigned WORD_W = 16;
   localparam int unsigned ACC_W = 32;
   localparam int unsigned VEC_W = 5;
   localparam int unsigned WAIT_W = 4;
   localparam int unsigned REP_W = 8;
   localparam int unsigned CYC_W = 16;
   localparam int unsigned SHAMT_W = 5;

   // Opcode patterns in the upper bits of the first word
   localparam logic [10:0] SWI_PATTERN = 11'h5F3;
   localparam logic [3:0] SHL_MEM_TOP = 4'h1;
   localparam logic [7:0] SHL16_TOP = 8'h6A;
   localparam logic [11:0] SHL_CONST_TOP = 12'hBF8;
   localparam logic [7:0] LOW_MEM_TOP = 8'h69;
   localparam logic [7:0] LOW_IMM_TOP = 8'hB9;

   // Field positions
   localparam int unsigned SHIFT_LSB = 8;
   localparam int unsigned CONST_SHIFT_LSB = 0;
   localparam int unsigned INDIRECT_BIT = 7;
   localparam int unsigned AUX_MODE_LSB = 4;
   localparam int unsigned AUX_NEXT_EN_BIT = 3;
   localparam int unsigned AUX_NEXT_LSB = 0;

   // Fixed figures
   localparam logic [SHAMT_W-1:0] FIXED_SHIFT = 5'h10;
   localparam logic [CYC_W-1:0] SWI_BASE_CYCLES = 16'h0004;
   localparam logic [CYC_W-1:0] SWI_WAIT_MULT = 16'h0003;
   localparam logic [CYC_W-1:0] CONST_BASE_CYCLES = 16'h0002;
   localparam logic [CYC_W-1:0] CONST_WAIT_MULT = 16'h0002;
   localparam logic [CYC_W-1:0] SHARED_EXTRA = 16'h0001;
   localparam logic [CYC_W-1:0] BOTH_EXT_EXTRA = 16'h0001;
   localparam logic [1:0] SPEC_FETCH_WORDS = 2'h2;

   // Values after reset
   localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
   localparam logic [2:0] AUX_PTR_RESET = 3'h0;

   typedef enum {ST_IDLE, ST_EXEC} state_e;
   typedef enum {OP_NONE, OP_SWI, OP_SHL_MEM, OP_SHL_CONST, OP_LOW_MEM, OP_LOW_IMM} op_e;
endpackage

/* logic/soft_interrupt_and_acc_load.sv */
// How it works
// [RULE1] Software interrupt carries a 5-bit index and jumps to that vector.
// [RULE2] Software interrupt pushes PC plus one as the return address.
// [RULE3] Software interrupt is never blocked by any interrupt mask.
// [RULE4] External vectors get an acknowledge pulse and set the global mask.
// [RULE5] Software interrupt takes 4 cycles, or 4+3p from external code.
// [RULE6] Two speculatively fetched words after the branch are discarded.
// [RULE7] Shifted load takes a 0..15 shift from bits 11..8.
// [RULE8] A separate form shifts the operand left by exactly 16.
// [RULE9] Long-immediate form takes its constant from the second word.
// [RULE10] Shift fills zeros low; high bits sign extend only when mode is set.
// [RULE11] Direct form gives 7 address bits; bit 7 selects indirect addressing.
// [RULE12] Indirect form passes update option and may pick next aux pointer.
// [RULE13] Single memory load: 1, 2 shared block, 1+d, 2+d+p.
// [RULE14] Long-immediate load: 2 cycles, or 2+2p from external code.
// [RULE15] Repeated load: n, n+nd, n+1+p+nd.
// [RULE16] Immediate low load: 1 cycle, or 1+p from external code.
// [RULE17] Repeated low load: n, n+1 shared block, n+nd.
// [RULE18] Interrupt opcode is 10111110011 in bits 15..5, index in 4..0.
// [RULE19] Low load puts operand in bits 15..0, clears the upper half.
// [RULE20] Vector address is twice the index, two words per vector.
`timescale 1ns/1ps
`default_nettype none
module soft_interrupt_and_acc_load
   import cpu_slice_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Instruction stream
   input wire logic instrValid,
   input wire logic [cpu_slice_pkg::WORD_W-1:0] instrWord,
   input wire logic [cpu_slice_pkg::WORD_W-1:0] pc,
   output logic instrReady,
   // Memory placement and waits
   input wire logic codeExternal,
   input wire logic codeOperandSameBlock,
   input wire logic operandExternal,
   input wire logic [cpu_slice_pkg::WAIT_W-1:0] progWaitStates,
   input wire logic [cpu_slice_pkg::WAIT_W-1:0] dataWaitStates,
   // Repeat control
   input wire logic repeatActive,
   input wire logic [cpu_slice_pkg::REP_W-1:0] repeatCount,
   // Operand and status
   input wire logic [cpu_slice_pkg::WORD_W-1:0] operandData,
   input wire logic signExtendModeBit,
   input wire logic [31:0] extVectorMask,
   // Accumulator
   output logic [cpu_slice_pkg::ACC_W-1:0] acc,
   output logic accWrite,
   // Data address and aux unit
   output logic [6:0] dataAddrLow,
   output logic indirectMode,
   output logic auxUpdate,
   output logic [2:0] auxMode,
   output logic [2:0] auxPointer,
   // Program flow
   output logic stackPush,
   output logic [cpu_slice_pkg::WORD_W-1:0] stackData,
   output logic pcLoad,
   output logic [cpu_slice_pkg::WORD_W-1:0] pcTarget,
   output logic intAck,
   output logic globalIrqMaskSet,
   output logic [1:0] discardedWords,
   output logic busy,
   output logic done
);
   typedef struct packed {
      state_e st;
      op_e op;
      logic [CYC_W-1:0] cnt;
      logic [WORD_W-1:0] word;
      logic [WORD_W-1:0] konst;
      logic haveConst;
      logic [WORD_W-1:0] retAddr;
      logic [ACC_W-1:0] acc;
      logic accWrite;
      logic [6:0] dataAddrLow;
      logic indirectMode;
      logic auxUpdate;
      logic [2:0] auxMode;
      logic [2:0] auxPointer;
      logic stackPush;
      logic [WORD_W-1:0] stackData;
      logic pcLoad;
      logic [WORD_W-1:0] pcTarget;
      logic intAck;
      logic globalIrqMaskSet;
      logic [1:0] discardedWords;
      logic busy;
      logic ready;
      logic done;
   } state_s;

   state_s cur;
   state_s nxt;
   op_e decOp;
   logic [CYC_W-1:0] decCycles;
   logic [CYC_W-1:0] repN;
   logic [CYC_W-1:0] pWait;
   logic [CYC_W-1:0] dWait;
   logic [WORD_W-1:0] shiftSrc;
   logic [SHAMT_W-1:0] shiftAmt;
   logic shiftSext;
   logic [ACC_W-1:0] shifted;

   // Decode of the first word
   always_comb begin
      decOp = OP_NONE;
      if (instrWord[15:5] == SWI_PATTERN) begin
         decOp = OP_SWI; // RULE18
      end else if (instrWord[15:4] == SHL_CONST_TOP) begin
         decOp = OP_SHL_CONST; // RULE9
      end else if (instrWord[15:12] == SHL_MEM_TOP || instrWord[15:8] == SHL16_TOP) begin
         decOp = OP_SHL_MEM; // RULE7 RULE8
      end else if (instrWord[15:8] == LOW_MEM_TOP) begin
         decOp = OP_LOW_MEM;
      end else if (instrWord[15:8] == LOW_IMM_TOP) begin
         decOp = OP_LOW_IMM;
      end
   end

   // Cycle budget; a repeat count of zero counts as one pass
   always_comb begin
      pWait = {{(CYC_W-WAIT_W){1'b0}}, progWaitStates};
      dWait = {{(CYC_W-WAIT_W){1'b0}}, dataWaitStates};
      repN = 16'h0001;
      if (repeatActive && repeatCount != 8'h00) begin
         repN = {{(CYC_W-REP_W){1'b0}}, repeatCount};
      end
      decCycles = repN;
      case (decOp)
         OP_SWI: begin
            decCycles = SWI_BASE_CYCLES + (codeExternal ? CYC_W'(SWI_WAIT_MULT * pWait) : 16'h0000); // RULE5
         end
         OP_SHL_CONST: begin
            decCycles = CONST_BASE_CYCLES + (codeExternal ? CYC_W'(CONST_WAIT_MULT * pWait) : 16'h0000); // RULE14
         end
         OP_LOW_IMM: begin
            decCycles = repN + (codeExternal ? pWait : 16'h0000); // RULE16
         end
         OP_SHL_MEM, OP_LOW_MEM: begin
            if (operandExternal) begin
               decCycles = repN + CYC_W'(repN * dWait); // RULE13 RULE15 RULE17
               if (codeExternal) begin
                  decCycles = decCycles + BOTH_EXT_EXTRA + pWait; // RULE13 RULE15
               end
            end else if (codeExternal) begin
               decCycles = repN + pWait;
            end else if (codeOperandSameBlock) begin
               decCycles = repN + SHARED_EXTRA; // RULE13 RULE17
            end
         end
         default: begin
            decCycles = repN;
         end
      endcase
   end

   // Shift source and amount for the load being finished
   always_comb begin
      shiftSrc = operandData;
      shiftAmt = {1'b0, cur.word[SHIFT_LSB+3:SHIFT_LSB]}; // RULE7
      shiftSext = signExtendModeBit; // RULE10
      case (cur.op)
         OP_SHL_CONST: begin
            shiftSrc = cur.konst; // RULE9
            shiftAmt = {1'b0, cur.word[CONST_SHIFT_LSB+3:CONST_SHIFT_LSB]};
         end
         OP_SHL_MEM: begin
            if (cur.word[15:8] == SHL16_TOP) begin
               shiftAmt = FIXED_SHIFT; // RULE8
            end
         end
         OP_LOW_MEM: begin
            shiftAmt = '0;
            shiftSext = 1'b0; // RULE19
         end
         OP_LOW_IMM: begin
            shiftSrc = {8'h00, cur.word[7:0]};
            shiftAmt = '0;
            shiftSext = 1'b0; // RULE19
         end
         default: begin
            shiftAmt = '0;
         end
      endcase
   end

   acc_shifter #(
      .IN_W(WORD_W),
      .OUT_W(ACC_W)
   ) u_shifter (
      .operand(shiftSrc),
      .shiftAmount(shiftAmt),
      .signExtend(shiftSext),
      .result(shifted)
   );

   // Next state; pulses fall back to zero every cycle
   always_comb begin
      nxt = cur;
      nxt.accWrite = 1'b0;
      nxt.auxUpdate = 1'b0;
      nxt.stackPush = 1'b0;
      nxt.pcLoad = 1'b0;
      nxt.intAck = 1'b0;
      nxt.globalIrqMaskSet = 1'b0;
      nxt.done = 1'b0;
      case (cur.st)
         ST_IDLE: begin
            if (instrValid && decOp != OP_NONE) begin
               nxt.st = ST_EXEC;
               nxt.op = decOp;
               nxt.cnt = decCycles;
               nxt.word = instrWord;
               nxt.haveConst = 1'b0;
               nxt.retAddr = pc + 16'h0001; // RULE2
               nxt.discardedWords = 2'h0;
               nxt.busy = 1'b1;
               nxt.ready = 1'b0;
               if (decOp == OP_SHL_MEM || decOp == OP_LOW_MEM) begin
                  nxt.indirectMode = instrWord[INDIRECT_BIT]; // RULE11
                  nxt.dataAddrLow = instrWord[6:0]; // RULE11
               end
            end
         end
         ST_EXEC: begin
            // Second word is the constant; words after a branch are dropped
            if (instrValid && cur.op == OP_SHL_CONST && !cur.haveConst) begin
               nxt.konst = instrWord; // RULE9
               nxt.haveConst = 1'b1;
            end else if (instrValid && cur.op == OP_SWI && cur.discardedWords != SPEC_FETCH_WORDS) begin
               nxt.discardedWords = cur.discardedWords + 2'h1; // RULE6
            end
            nxt.cnt = cur.cnt - 16'h0001;
            if (cur.cnt <= 16'h0001) begin
               nxt.st = ST_IDLE;
               nxt.op = OP_NONE;
               nxt.busy = 1'b0;
               nxt.ready = 1'b1;
               nxt.done = 1'b1;
               if (cur.op == OP_SWI) begin
                  // No interrupt mask gates the branch; extVectorMask only selects the acknowledge
                  nxt.stackPush = 1'b1; // RULE2 RULE3
                  nxt.stackData = cur.retAddr;
                  nxt.pcLoad = 1'b1; // RULE1
                  nxt.pcTarget = {10'h000, cur.word[4:0], 1'b0}; // RULE20
                  nxt.globalIrqMaskSet = 1'b1; // RULE4
                  nxt.intAck = extVectorMask[cur.word[4:0]]; // RULE4
                  nxt.discardedWords = SPEC_FETCH_WORDS; // RULE6
               end else begin
                  nxt.acc = shifted; // RULE10 RULE19
                  nxt.accWrite = 1'b1;
                  if ((cur.op == OP_SHL_MEM || cur.op == OP_LOW_MEM) && cur.word[INDIRECT_BIT]) begin
                     nxt.auxUpdate = 1'b1; // RULE12
                     nxt.auxMode = cur.word[AUX_MODE_LSB+2:AUX_MODE_LSB];
                     if (cur.word[AUX_NEXT_EN_BIT]) begin
                        nxt.auxPointer = cur.word[AUX_NEXT_LSB+2:AUX_NEXT_LSB]; // RULE12
                     end
                  end
               end
            end
         end
         default: begin
            nxt.st = ST_IDLE;
         end
      endcase
   end

   // Single state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cur <= '0;
         cur.st <= ST_IDLE;
         cur.op <= OP_NONE;
         cur.acc <= ACC_RESET;
         cur.auxPointer <= AUX_PTR_RESET;
         cur.ready <= 1'b1;
      end else begin
         cur <= nxt;
      end
   end

   // Outputs straight from the state register
   always_comb begin
      instrReady = cur.ready;
      acc = cur.acc;
      accWrite = cur.accWrite;
      dataAddrLow = cur.dataAddrLow;
      indirectMode = cur.indirectMode;
      auxUpdate = cur.auxUpdate;
      auxMode = cur.auxMode;
      auxPointer = cur.auxPointer;
      stackPush = cur.stackPush;
      stackData = cur.stackData;
      pcLoad = cur.pcLoad;
      pcTarget = cur.pcTarget;
      intAck = cur.intAck;
      globalIrqMaskSet = cur.globalIrqMaskSet;
      discardedWords = cur.discardedWords;
      busy = cur.busy;
      done = cur.done;
   end
endmodule
`default_nettype wire

/* verif/mem_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mem_side_model (
   // Clock
   input wire logic sys_clk,
   // Bench side
   input wire logic [15:0] presetWord,
   // Design side
   input wire logic stackPush,
   input wire logic [15:0] stackData,
   output logic [15:0] operandData,
   output logic [15:0] stackTop
);
   // Read port held steady, since the device samples only in its last cycle
   assign operandData = presetWord;
   // Hardware stack top keeps the return address
   always_ff @(posedge sys_clk) begin
      if (stackPush) begin
         stackTop <= stackData;
      end
   end
endmodule
`default_nettype wire

/* verif/soft_interrupt_and_acc_load_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module soft_interrupt_and_acc_load_sva
   import cpu_slice_pkg::*;
(
   // Clock, reset and request side
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic instrValid,
   input wire logic [15:0] instrWord,
   input wire logic [15:0] pc,
   input wire logic instrReady,
   input wire logic codeExternal,
   input wire logic codeOperandSameBlock,
   input wire logic operandExternal,
   input wire logic repeatActive,
   // Results
   input wire logic [31:0] acc,
   input wire logic accWrite,
   input wire logic indirectMode,
   input wire logic auxUpdate,
   input wire logic stackPush,
   input wire logic [15:0] stackData,
   input wire logic pcLoad,
   input wire logic [15:0] pcTarget,
   input wire logic intAck,
   input wire logic globalIrqMaskSet,
   input wire logic busy,
   input wire logic done
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Accepts with no wait states, so every figure below is exact
   wire logic take = instrReady && instrValid;
   wire logic swiGo = take && instrWord[15:5] == SWI_PATTERN && !codeExternal;
   wire logic lkGo = take && instrWord[15:4] == SHL_CONST_TOP && !codeExternal;
   wire logic immGo = take && instrWord[15:8] == LOW_IMM_TOP && !codeExternal && !repeatActive;
   wire logic memGo = take && instrWord[15:12] == SHL_MEM_TOP && !codeExternal && !operandExternal
      && !codeOperandSameBlock && !repeatActive;

   chk_swi_timing: assert property (swiGo |-> ##1 busy [*4] ##1 (done && stackPush && pcLoad))
      else $error("software interrupt length wrong");
   chk_swi_vector: assert property (swiGo |-> ##5 pcTarget == {10'h000, $past(instrWord[4:0], 5), 1'b0})
      else $error("vector address wrong");
   chk_swi_return: assert property (swiGo |-> ##5 stackData == $past(pc, 5) + 16'h0001)
      else $error("return address wrong");
   chk_ack_mask: assert property (intAck |-> pcLoad && globalIrqMaskSet)
      else $error("acknowledge without mask set");
   chk_mask_always: assert property (pcLoad |-> globalIrqMaskSet && stackPush)
      else $error("mask or push missing on branch");
   chk_mem_single: assert property (memGo |-> ##1 busy ##1 (done && accWrite))
      else $error("single load length wrong");
   chk_lk_two: assert property (lkGo |-> ##1 busy [*2] ##1 (done && accWrite))
      else $error("long immediate length wrong");
   chk_imm_low: assert property (immGo |-> ##2 accWrite && acc == {24'h000000, $past(instrWord[7:0], 2)})
      else $error("low immediate load wrong");
   chk_aux_indirect: assert property (auxUpdate |-> done && indirectMode)
      else $error("aux update outside indirect load");
endmodule
bind soft_interrupt_and_acc_load soft_interrupt_and_acc_load_sva i_soft_interrupt_and_acc_load_sva (
   .sys_clk(sys_clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord), .pc(pc),
   .instrReady(instrReady), .codeExternal(codeExternal), .codeOperandSameBlock(codeOperandSameBlock),
   .operandExternal(operandExternal), .repeatActive(repeatActive), .acc(acc), .accWrite(accWrite),
   .indirectMode(indirectMode), .auxUpdate(auxUpdate), .stackPush(stackPush), .stackData(stackData),
   .pcLoad(pcLoad), .pcTarget(pcTarget), .intAck(intAck), .globalIrqMaskSet(globalIrqMaskSet),
   .busy(busy), .done(done));
`default_nettype wire

/* verif/soft_interrupt_and_acc_load_test.sv */
`timescale 1ns/1ps
`default_nettype none
module soft_interrupt_and_acc_load_test;
   import cpu_slice_pkg::*;
   // Stimulus
   logic sys_clk, rst, instrValid, codeExternal, sameBlock, operandExternal, repeatActive, signExt;
   logic [15:0] instrWord, pc, presetWord;
   logic [3:0] progWaitStates, dataWaitStates;
   logic [7:0] repeatCount;
   logic [31:0] extVectorMask;
   // Observed
   wire logic [15:0] operandData, stackTop, stackData, pcTarget;
   wire logic [31:0] acc;
   wire logic [6:0] dataAddrLow;
   wire logic [2:0] auxMode, auxPointer;
   wire logic [1:0] discardedWords;
   wire logic instrReady, accWrite, indirectMode, auxUpdate, stackPush, pcLoad, intAck, maskSet, busy, done;
   int fails = 0;
   int nTests = 0;
   int cycles = 0;

   soft_interrupt_and_acc_load i_soft_interrupt_and_acc_load (.sys_clk(sys_clk), .rst(rst),
      .instrValid(instrValid), .instrWord(instrWord), .pc(pc), .instrReady(instrReady),
      .codeExternal(codeExternal), .codeOperandSameBlock(sameBlock), .operandExternal(operandExternal),
      .progWaitStates(progWaitStates), .dataWaitStates(dataWaitStates), .repeatActive(repeatActive),
      .repeatCount(repeatCount), .operandData(operandData), .signExtendModeBit(signExt),
      .extVectorMask(extVectorMask), .acc(acc), .accWrite(accWrite), .dataAddrLow(dataAddrLow),
      .indirectMode(indirectMode), .auxUpdate(auxUpdate), .auxMode(auxMode), .auxPointer(auxPointer),
      .stackPush(stackPush), .stackData(stackData), .pcLoad(pcLoad), .pcTarget(pcTarget), .intAck(intAck),
      .globalIrqMaskSet(maskSet), .discardedWords(discardedWords), .busy(busy), .done(done));
   mem_side_model i_mem_side_model (.sys_clk(sys_clk), .presetWord(presetWord), .stackPush(stackPush),
      .stackData(stackData), .operandData(operandData), .stackTop(stackTop));

   // Clock and hang guard; a run is about 130 cycles
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         finalReport();
      end
   end

   task automatic finalReport();
      if (fails == 0 && nTests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] expVal, input logic [31:0] gotVal);
      nTests++;
      if (gotVal !== expVal) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, expVal, gotVal);
      end
   endtask

   task automatic place(input logic ce, ss, oe, input logic [3:0] p, d, input logic rp, input logic [7:0] n);
      codeExternal = ce;
      sameBlock = ss;
      operandExternal = oe;
      progWaitStates = p;
      dataWaitStates = d;
      repeatActive = rp;
      repeatCount = n;
   endtask

   // Offer a word at this falling edge, keep extra words up, count edges to done
   task automatic run(input logic [15:0] w, nxt, input int extra, cyc);
      int n;
      instrWord = w;
      instrValid = 1'b1;
      @(negedge sys_clk);
      instrWord = nxt;
      instrValid = extra > 0;
      n = 1;
      while (done !== 1'b1 && n < 80) begin
         @(negedge sys_clk);
         n++;
         if (n == extra + 1) instrValid = 1'b0;
      end
      check("cycles", 32'(cyc + 1), 32'(n));
   endtask

   task automatic load(input logic [15:0] w, k, opnd, input logic s, input logic [31:0] expAcc, input int cyc);
      presetWord = opnd;
      signExt = s;
      run(w, k, (w[15:4] == SHL_CONST_TOP) ? 1 : 0, cyc);
      check("acc", expAcc, acc);
      check("accWrite", 32'h00000001, 32'(accWrite));
   endtask

   // Discard words are live load opcodes and must not execute
   task automatic swi(input logic [4:0] k, input logic ext, input logic [3:0] p, input int cyc);
      place(ext, 1'b0, 1'b0, p, 4'h0, 1'b0, 8'h00);
      pc = 16'hFFE0 | 16'(k);
      run({SWI_PATTERN, k}, 16'h1406, 2, cyc);
      check("pcTarget", 32'(k) * 2, 32'(pcTarget));
      check("stackData", {16'h0000, pc + 16'h0001}, 32'(stackData));
      check("flow", {26'h0, k == 5'h03, 3'h7, 2'h2},
         {26'h0, intAck, maskSet, stackPush, pcLoad, discardedWords});
      // The stack takes the push at the edge that ends the pulse
      @(negedge sys_clk);
      check("stackTop", {16'h0000, pc + 16'h0001}, 32'(stackTop));
   endtask

   task automatic shiftedLoads();
      place(1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 1'b0, 8'h00);
      load(16'h1406, 16'h0, 16'h0001, 1'b0, 32'h00000010, 1);
      check("addr", 32'h06, 32'(dataAddrLow));
      load(16'h1F05, 16'h0, 16'h8001, 1'b1, 32'hC0008000, 1);
      load(16'h10AD, 16'h0, 16'hFF00, 1'b1, 32'hFFFFFF00, 1);
      check("aux", 32'h00000055, {25'h0, indirectMode, auxMode, auxPointer});
      load(16'h6A10, 16'h0, 16'h1234, 1'b0, 32'h12340000, 1);
      load(16'h6A92, 16'h0, 16'hFFFF, 1'b1, 32'hFFFF0000, 1);
      check("auxKeep", 32'h0000004D, {25'h0, indirectMode, auxMode, auxPointer});
      load(16'hBF81, 16'hF000, 16'h0, 1'b1, 32'hFFFFE000, 2);
      load(16'h6907, 16'h0, 16'hFFFF, 1'b1, 32'h0000FFFF, 1);
      load(16'hB95A, 16'h0, 16'h0, 1'b1, 32'h0000005A, 1);
      place(1'b1, 1'b0, 1'b0, 4'h3, 4'h0, 1'b0, 8'h00);
      load(16'hBF80, 16'h8000, 16'h0, 1'b0, 32'h00008000, 8);
      place(1'b1, 1'b0, 1'b0, 4'h2, 4'h0, 1'b0, 8'h00);
      load(16'hB9A5, 16'h0, 16'h0, 1'b1, 32'h000000A5, 3);
   endtask

   // Placement and repeat figures on the memory forms
   task automatic loadTiming();
      place(1'b0, 1'b1, 1'b0, 4'h0, 4'h0, 1'b0, 8'h00);
      load(16'h1000, 16'h0, 16'h0001, 1'b0, 32'h00000001, 2);
      place(1'b0, 1'b0, 1'b1, 4'h0, 4'h3, 1'b0, 8'h00);
      load(16'h1000, 16'h0, 16'h0001, 1'b0, 32'h00000001, 4);
      place(1'b1, 1'b0, 1'b1, 4'h2, 4'h3, 1'b0, 8'h00);
      load(16'h1000, 16'h0, 16'h0001, 1'b0, 32'h00000001, 7);
      place(1'b1, 1'b0, 1'b0, 4'h2, 4'h0, 1'b0, 8'h00);
      load(16'h1000, 16'h0, 16'h0001, 1'b0, 32'h00000001, 3);
      place(1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 1'b1, 8'h03);
      load(16'h1000, 16'h0, 16'h0002, 1'b0, 32'h00000002, 3);
      place(1'b0, 1'b0, 1'b1, 4'h0, 4'h2, 1'b1, 8'h03);
      load(16'h1000, 16'h0, 16'h0002, 1'b0, 32'h00000002, 9);
      place(1'b1, 1'b0, 1'b1, 4'h1, 4'h2, 1'b1, 8'h03);
      load(16'h1000, 16'h0, 16'h0002, 1'b0, 32'h00000002, 11);
      place(1'b0, 1'b1, 1'b0, 4'h0, 4'h0, 1'b1, 8'h04);
      load(16'h6900, 16'h0, 16'h0003, 1'b0, 32'h00000003, 5);
      place(1'b0, 1'b0, 1'b1, 4'h0, 4'h1, 1'b1, 8'h04);
      load(16'h6900, 16'h0, 16'h0003, 1'b0, 32'h00000003, 8);
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      instrValid = 1'b0;
      instrWord = 16'h0000;
      pc = 16'h0000;
      presetWord = 16'h0000;
      signExt = 1'b0;
      extVectorMask = 32'h00000008;
      place(1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 1'b0, 8'h00);
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      check("idle", 32'h00000001, {28'h0, auxPointer, instrReady});
      check("accReset", 32'h0, acc);
      swi(5'h00, 1'b0, 4'h0, 4);
      swi(5'h03, 1'b0, 4'h0, 4);
      swi(5'h1F, 1'b1, 4'h2, 10);
      swi(5'h03, 1'b1, 4'h1, 7);
      shiftedLoads();
      loadTiming();
      finalReport();
   end
endmodule
`default_nettype wire
